// file: src/clpv_crtc_line.sv
`timescale 1ns/10ps
module clpv_crtc_line
    import clpv_pkg::*;
#(
    parameter int AW = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire clpv_io_req_t ioReq,
    output logic [7:0] ioRdata,
    output logic ioRdHit,
    input wire logic [1:0] pitchHigh,
    input wire logic [AW-1:0] startAddress,
    input wire logic vbStartBit8,
    input wire logic vbStartBit9,
    input wire logic vbStartBit10,
    input wire logic byteModeSel,
    input wire logic addrSize15,
    input wire logic frameStart,
    input wire logic lineStart,
    input wire logic charTick,
    input wire logic displayActive,
    input wire logic [10:0] scanLine,
    input wire logic textMode,
    input wire logic [3:0] rowScan,
    input wire logic [7:0] charAttr,
    output logic [AW-1:0] fbAddr,
    output logic [9:0] lineWidth,
    output logic underlineOn,
    output logic vertBlank
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (AW < 16) begin : g_aw_check
        $error("clpv_crtc_line: AW must be at least 16");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] pitchLow;
        logic [7:0] ulMode;
        logic [7:0] vbStartLow;
        logic [7:0] vbEnd;
        logic [AW-1:0] lineAddr;
        logic [AW-1:0] count;
        logic [1:0] div4;
        logic [AW-1:0] fbAddr;
        logic underline;
        logic blank;
        logic [7:0] rdata;
        logic rdHit;
    } clpv_state_t;

    clpv_state_t st_r;
    clpv_state_t st_nxt;

    logic double_word_addressing;
    logic cb4;
    logic [3:0] ulRow;
    logic ulEnable;
    logic [10:0] vbStart;
    logic [AW-1:0] lineStep;
    logic countAdvance;
    logic attrMatch;
    logic [AW-1:0] mappedAddr;

    assign lineWidth = {pitchHigh, st_r.pitchLow};
    assign double_word_addressing = st_r.ulMode[CLPV_BIT_DWM];
    assign cb4 = st_r.ulMode[CLPV_BIT_CB4];
    assign ulRow = st_r.ulMode[CLPV_UL_ROW_HI:CLPV_UL_ROW_LO];
    assign ulEnable = st_r.ulMode[CLPV_BIT_UL_EN];
    assign vbStart = {vbStartBit10, vbStartBit9, vbStartBit8, st_r.vbStartLow};

    // Line step in counter units
    assign lineStep = double_word_addressing ? (AW'(lineWidth) << CLPV_DWORD_STEP_SHIFT)
        : (AW'(lineWidth) << CLPV_NORMAL_STEP_SHIFT);
    assign countAdvance = charTick && displayActive
        && (!cb4 || st_r.div4 == CLPV_CB4_LAST);
    assign attrMatch = (charAttr & CLPV_UL_ATTR_MASK) == CLPV_UL_ATTR_VALUE;

    // ****************************************
    // Frame buffer address mapping
    // ****************************************
    // Word mode moves the counter up one bit, low bit from bit 13 or 15
    always_comb begin
        if (double_word_addressing) begin
            mappedAddr = {st_r.count[AW-3:0], st_r.count[13], st_r.count[12]};
        end else if (byteModeSel) begin
            mappedAddr = st_r.count;
        end else begin
            mappedAddr = {st_r.count[AW-2:0], addrSize15 ? st_r.count[15] : st_r.count[13]};
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdHit = 1'b0;
        // Index/data register port
        if (ioReq.write) begin
            if (!ioReq.dataSel) begin
                st_nxt.index = ioReq.wdata;
            end else begin
                case (st_r.index)
                    CLPV_IDX_LINE_PITCH_LOW: st_nxt.pitchLow = ioReq.wdata;
                    CLPV_IDX_UL_ADDR_MODE: st_nxt.ulMode = ioReq.wdata;
                    CLPV_IDX_VB_START_LOW: st_nxt.vbStartLow = ioReq.wdata;
                    CLPV_IDX_VB_END: st_nxt.vbEnd = ioReq.wdata;
                    default: st_nxt.index = st_r.index;
                endcase
            end
        end
        if (ioReq.read) begin
            st_nxt.rdHit = 1'b1;
            if (!ioReq.dataSel) begin
                st_nxt.rdata = st_r.index;
            end else begin
                case (st_r.index)
                    CLPV_IDX_LINE_PITCH_LOW: st_nxt.rdata = st_r.pitchLow;
                    CLPV_IDX_UL_ADDR_MODE: st_nxt.rdata = st_r.ulMode;
                    CLPV_IDX_VB_START_LOW: st_nxt.rdata = st_r.vbStartLow;
                    CLPV_IDX_VB_END: st_nxt.rdata = st_r.vbEnd;
                    default: begin
                        st_nxt.rdata = 8'h00;
                        st_nxt.rdHit = 1'b0;
                    end
                endcase
            end
        end
        // Memory address counter
        // Frame load beats line step; both restart the count-by-four phase
        if (frameStart) begin
            st_nxt.lineAddr = startAddress;
            st_nxt.count = startAddress;
            st_nxt.div4 = 2'h0;
        end else if (lineStart) begin
            st_nxt.lineAddr = st_r.lineAddr + lineStep;
            st_nxt.count = st_r.lineAddr + lineStep;
            st_nxt.div4 = 2'h0;
        end else begin
            if (charTick && displayActive) begin
                st_nxt.div4 = st_r.div4 + 2'h1;
            end
            if (countAdvance) begin
                st_nxt.count = st_r.count + AW'(1);
            end
        end
        st_nxt.fbAddr = mappedAddr;
        // Underline
        st_nxt.underline = ulEnable && textMode && attrMatch
            && (rowScan == ulRow);
        // Vertical blanking, start wins over end in the same line
        if (scanLine == vbStart) begin
            st_nxt.blank = 1'b1;
        end else if (scanLine[CLPV_VB_END_USED-1:0] == st_r.vbEnd[CLPV_VB_END_USED-1:0]) begin
            st_nxt.blank = 1'b0;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.index <= CLPV_RST_INDEX;
            st_r.pitchLow <= CLPV_RST_PITCH;
            st_r.ulMode <= CLPV_RST_UL_MODE;
            st_r.vbStartLow <= CLPV_RST_VB_START;
            st_r.vbEnd <= CLPV_RST_VB_END;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ioRdata = st_r.rdata;
    assign ioRdHit = st_r.rdHit;
    assign fbAddr = st_r.fbAddr;
    assign underlineOn = st_r.underline;
    assign vertBlank = st_r.blank;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_pitch_width: assert property (
        lineWidth[7:0] == st_r.pitchLow && lineWidth[9:8] == pitchHigh)
        else $error("line width not formed from pitch bits");
    a_pitch_write: assert property (
        ioReq.write && ioReq.dataSel && st_r.index == CLPV_IDX_LINE_PITCH_LOW
        |=> lineWidth[7:0] == $past(ioReq.wdata))
        else $error("line pitch write did not land");
    a_vb_end_write: assert property (
        ioReq.write && ioReq.dataSel && st_r.index == CLPV_IDX_VB_END
        |=> st_r.vbEnd == $past(ioReq.wdata))
        else $error("blank end register did not store all bits");
    a_vb_end_rw: assert property (
        ioReq.write && ioReq.dataSel && st_r.index == CLPV_IDX_VB_END
        ##1 ioReq.read && ioReq.dataSel && !ioReq.write
        |=> ioRdata == $past(ioReq.wdata, 2))
        else $error("blank end register not read back whole");

    // ****************************************
    // Address counter checks
    // ****************************************
    a_frame_start: assert property (
        frameStart |=> st_r.lineAddr == $past(startAddress)
        && st_r.count == $past(startAddress))
        else $error("frame did not load start address");
    a_step_normal: assert property (
        lineStart && !frameStart && !double_word_addressing
        |=> st_r.lineAddr == $past(st_r.lineAddr) + AW'({$past(lineWidth), 1'h0}))
        else $error("normal line step wrong");
    a_step_dword: assert property (
        lineStart && !frameStart && double_word_addressing
        |=> st_r.lineAddr == $past(st_r.lineAddr) + AW'({$past(lineWidth), 3'h0}))
        else $error("double word line step wrong");
    a_line_count: assert property (
        lineStart && !frameStart |=> st_r.count == st_r.lineAddr)
        else $error("counter not reloaded from new line start");
    a_dword_map: assert property (
        double_word_addressing ##1 1'b1 |-> fbAddr[1:0] == {$past(st_r.count[13]), $past(st_r.count[12])})
        else $error("double word low address bits wrong");
    a_dword_shift: assert property (
        double_word_addressing |=> fbAddr[AW-1:2] == $past(st_r.count[AW-3:0]))
        else $error("double word address not shifted by two");
    a_count_by4: assert property (
        cb4 && charTick && displayActive && st_r.div4 != CLPV_CB4_LAST
        && !lineStart && !frameStart |=> st_r.count == $past(st_r.count))
        else $error("counter advanced early in count-by-four");
    a_count_step: assert property (
        !cb4 && charTick && displayActive && !lineStart && !frameStart
        |=> st_r.count == $past(st_r.count) + AW'(1))
        else $error("counter did not advance on character clock");
    a_count_idle: assert property (
        !(charTick && displayActive) && !lineStart && !frameStart
        |=> st_r.count == $past(st_r.count))
        else $error("counter moved without a character clock");
    a_div4_clear: assert property (
        frameStart || lineStart |=> st_r.div4 == 2'h0)
        else $error("count-by-four phase not cleared at line start");

    // ****************************************
    // Underline and blanking checks
    // ****************************************
    a_ul_enable: assert property (!ulEnable |=> !underlineOn)
        else $error("underline drawn while disabled");
    a_ul_text: assert property (!textMode |=> !underlineOn)
        else $error("underline drawn outside text mode");
    a_ul_match: assert property (
        underlineOn |-> $past(attrMatch) && $past(textMode)
        && $past(rowScan) == $past(ulRow))
        else $error("underline without matching row and attribute");
    a_ul_row: assert property (
        ulEnable && textMode && attrMatch && rowScan == ulRow
        |=> underlineOn)
        else $error("underline missing on matching row");
    a_vb_start: assert property (scanLine == vbStart |=> vertBlank)
        else $error("blank not raised at start line");
    a_vb_end: assert property (
        scanLine != vbStart && scanLine[6:0] == st_r.vbEnd[6:0]
        |=> !vertBlank)
        else $error("blank not dropped at end line");
    a_vb_hold: assert property (
        scanLine != vbStart && scanLine[6:0] != st_r.vbEnd[6:0]
        |=> vertBlank == $past(vertBlank))
        else $error("blank changed away from start and end lines");

    // ****************************************
    // Cover points
    // ****************************************
    c_dword_step: cover property (lineStart && double_word_addressing && lineWidth != 10'h000);
    c_underline: cover property (underlineOn);
    c_blank_pulse: cover property (vertBlank ##1 !vertBlank);
    c_cb4_advance: cover property (cb4 && countAdvance);
    c_word_a15: cover property (!double_word_addressing && !byteModeSel && addrSize15 && lineStart);

endmodule

// file: src/clpv_pkg.sv
package clpv_pkg;

    // ****************************************
    // Register indices behind the index/data port pair
    // ****************************************
    localparam logic [7:0] CLPV_IDX_LINE_PITCH_LOW = 8'h13;
    localparam logic [7:0] CLPV_IDX_UL_ADDR_MODE = 8'h14;
    localparam logic [7:0] CLPV_IDX_VB_START_LOW = 8'h15;
    localparam logic [7:0] CLPV_IDX_VB_END = 8'h16;

    // ****************************************
    // Field positions of underline_and_addr_mode, and bits used of the blank end register
    // ****************************************
    localparam int CLPV_BIT_DWM = 6;
    localparam int CLPV_BIT_CB4 = 5;
    localparam int CLPV_UL_ROW_HI = 4;
    localparam int CLPV_UL_ROW_LO = 1;
    localparam int CLPV_BIT_UL_EN = 0;
    localparam int CLPV_VB_END_USED = 7;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0] CLPV_RST_INDEX = 8'h00;
    localparam logic [7:0] CLPV_RST_PITCH = 8'h00;
    localparam logic [7:0] CLPV_RST_UL_MODE = 8'h00;
    localparam logic [7:0] CLPV_RST_VB_START = 8'h00;
    localparam logic [7:0] CLPV_RST_VB_END = 8'h00;

    // ****************************************
    // Counts and attribute pattern
    // ****************************************
    localparam logic [1:0] CLPV_CB4_LAST = 2'h3;
    localparam logic [7:0] CLPV_UL_ATTR_MASK = 8'h77;
    localparam logic [7:0] CLPV_UL_ATTR_VALUE = 8'h01;
    localparam int CLPV_NORMAL_STEP_SHIFT = 1;
    localparam int CLPV_DWORD_STEP_SHIFT = 3;

    // ****************************************
    // Index/data port request
    // ****************************************
    typedef struct packed {
        logic dataSel;
        logic write;
        logic read;
        logic [7:0] wdata;
    } clpv_io_req_t;

endpackage

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench
    import clpv_pkg::*;
;
    // ****************************************
    // Design hookup
    // ****************************************
    logic clk, reset, ioRdHit, vbStartBit8, vbStartBit9, vbStartBit10, byteModeSel;
    logic addrSize15, frameStart, lineStart, charTick, displayActive, textMode;
    logic underlineOn, vertBlank;
    clpv_io_req_t ioReq;
    logic [7:0] ioRdata, charAttr;
    logic [1:0] pitchHigh;
    logic [19:0] startAddress, fbAddr;
    logic [10:0] scanLine;
    logic [3:0] rowScan;
    logic [9:0] lineWidth;
    int miscompares, n_compared, cyc;
    logic [31:0] seed = 32'h33;
    logic [7:0] m [4];

    clpv_crtc_line #(.AW(20)) dut (.clk(clk), .reset(reset), .ioReq(ioReq),
        .ioRdata(ioRdata), .ioRdHit(ioRdHit), .pitchHigh(pitchHigh),
        .startAddress(startAddress), .vbStartBit8(vbStartBit8), .vbStartBit9(vbStartBit9),
        .vbStartBit10(vbStartBit10), .byteModeSel(byteModeSel), .addrSize15(addrSize15),
        .frameStart(frameStart), .lineStart(lineStart), .charTick(charTick),
        .displayActive(displayActive), .scanLine(scanLine), .textMode(textMode),
        .rowScan(rowScan), .charAttr(charAttr), .fbAddr(fbAddr), .lineWidth(lineWidth),
        .underlineOn(underlineOn), .vertBlank(vertBlank));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [19:0] mapAddr(input logic [19:0] c, input logic dw, bm, a15);
        if (dw) return {c[17:0], c[13], c[12]};
        if (bm) return c;
        return {c[18:0], a15 ? c[15] : c[13]};
    endfunction

    task automatic tally_and_finish();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic io(input logic sel, w, r, input logic [7:0] d);
        ioReq = '{dataSel: sel, write: w, read: r, wdata: d};
        step();
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        io(1'b0, 1'b1, 1'b0, idx);
        io(1'b1, 1'b1, 1'b0, d);
        ioReq = '0;
        m[idx - 8'h13] = d;
        step();
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic h);
        io(1'b0, 1'b1, 1'b0, idx);
        io(1'b1, 1'b0, 1'b1, 8'h00);
        d = ioRdata;
        h = ioRdHit;
        ioReq = '0;
        step();
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            $display("FAIL %0t run did not end in time", $time);
            tally_and_finish();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] v;
        logic [19:0] s, e;
        logic [7:0] d;
        logic h, x;
        logic [10:0] st, sl;
        reset = 1'b1;
        ioReq = '0;
        {pitchHigh, startAddress, vbStartBit8, vbStartBit9, vbStartBit10} = '0;
        {byteModeSel, addrSize15, frameStart, lineStart, charTick, displayActive} = '0;
        {scanLine, textMode, rowScan, charAttr} = '0;
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(8'h13 + i[7:0], d, h);
            chk({12'h0, d}, 20'h0, "reset value");
            v = rnd();
            if (i == 1) v[7] = 1'b0;
            wr(8'h13 + i[7:0], v[7:0]);
            rd(8'h13 + i[7:0], d, h);
            chk({12'h0, d}, {12'h0, m[i]}, "readback");
            chkBit(h, 1'b1, "read hit");
        end
        io(1'b0, 1'b1, 1'b0, 8'h16);
        v = rnd();
        io(1'b1, 1'b1, 1'b0, v[7:0]);
        io(1'b1, 1'b0, 1'b1, 8'h00);
        m[3] = v[7:0];
        chk({12'h0, ioRdata}, {12'h0, m[3]}, "write then read");
        chkBit(ioRdHit, 1'b1, "write then read hit");
        rd(8'h17, d, h);
        chkBit(h, 1'b0, "unmapped hit");
        chk({12'h0, d}, 20'h0, "unmapped data");
        $display("register test done");
        for (int mode = 0; mode < 4; mode++) begin
            v = rnd();
            byteModeSel = (mode == 0) | (mode == 3 & v[20]);
            addrSize15 = (mode == 2) | (mode == 3 & v[21]);
            pitchHigh = v[23:22];
            x = (mode == 3);
            wr(8'h14, {1'b0, x, 6'h00});
            wr(8'h13, v[7:0]);
            chk({10'h0, lineWidth}, {10'h0, pitchHigh, m[0]}, "line width");
            v = rnd();
            s = v[19:0];
            startAddress = s;
            frameStart = 1'b1;
            step();
            frameStart = 1'b0;
            repeat (3) step();
            chk(fbAddr, mapAddr(s, x, byteModeSel, addrSize15), "start");
            for (int k = 0; k < 2; k++) begin
                lineStart = 1'b1;
                step();
                lineStart = 1'b0;
                repeat (3) step();
                s = s + ({10'h0, pitchHigh, m[0]} << (x ? 3 : 1));
                chk(fbAddr, mapAddr(s, x, byteModeSel, addrSize15), "step");
            end
        end
        $display("address test done");
        byteModeSel = 1'b1;
        for (int cb = 0; cb < 2; cb++) begin
            wr(8'h14, {2'b00, cb == 1, 5'h00});
            v = rnd();
            s = v[19:0];
            startAddress = s;
            displayActive = 1'b1;
            frameStart = 1'b1;
            step();
            frameStart = 1'b0;
            charTick = 1'b1;
            repeat (8) step();
            charTick = 1'b0;
            repeat (3) step();
            e = s + ((cb == 1) ? 20'h2 : 20'h8);
            chk(fbAddr, e, "count advance");
            displayActive = 1'b0;
        end
        $display("count test done");
        for (int k = 0; k < 60; k++) begin
            v = rnd();
            wr(8'h14, {1'b0, v[6:0]});
            textMode = v[8];
            charAttr = v[9] ? ((v[23:16] & 8'h88) | 8'h01) : v[23:16];
            rowScan = v[10] ? m[1][4:1] : v[27:24];
            step();
            x = m[1][0] & textMode & ((charAttr & 8'h77) == 8'h01) & (rowScan == m[1][4:1]);
            chkBit(underlineOn, x, "underline");
        end
        wr(8'h14, 8'h1f);
        {textMode, charAttr} = {1'b1, 8'h01};
        for (int k = 0; k < 8; k++) begin
            rowScan = k[3:0];
            step();
            chkBit(underlineOn, 1'b0, "row above cell");
        end
        $display("underline test done");
        for (int r = 0; r < 2; r++) begin
            v = rnd();
            v[15] = (r == 0);
            wr(8'h15, v[7:0]);
            wr(8'h16, {v[15], v[6:0] + v[14:8]});
            {vbStartBit10, vbStartBit9, vbStartBit8} = v[18:16];
            st = {v[18:16], v[7:0]};
            scanLine = st;
            step();
            x = 1'b1;
            chkBit(vertBlank, x, "blank start");
            for (int k = 1; k <= 2048; k++) begin
                sl = st + k[10:0];
                scanLine = sl;
                step();
                if (sl == st) x = 1'b1;
                else if (sl[6:0] == m[3][6:0]) x = 1'b0;
                chkBit(vertBlank, x, "blank sweep");
            end
        end
        $display("blank test done");
        tally_and_finish();
    end
endmodule
